// file: common/stv_pkg.sv
// Behaviour
// (R1) One trim step adjusts the reference by one sixty-fourth of a sample period.
// (R2) Trim is signed, held, shown and stepped within -999 to +999.
// (R3) Trim item appears after Up held plus Clock Ref tap on video system item.
// (R4) Set while editing trim commits it and returns to time-code readout.
// (R5) After commit, Set shows the trim item again; Down there hides it.
// (R6) Firmware update and factory restore leave the stored trim unchanged.
// (R7) Up and Down held at power-up restore defaults and show the banner.
// (R8) Restore: AES/EBU reference, 44.1 kHz, freewheel 8 frames, 100 pulses per frame.
// (R9) Restore: start time zero, lines 14-16, servo -1, insert/burn/idle on, others off.
// (R10) Resolver reference may be switched to any input at any time; APB access stalls during load, store and trim edit.
// (R11) Video clock reference with Generate routes the reference input to VITC path.
// (R12) Any other combination routes the program video input to VITC path.
// (R13) Frame edges of the selected input time the time-code path.
// (R14) Committed settings are kept in non-volatile storage across power cycles.
// (R15) Committed trim drives the oscillator control at once and persists.
package stv_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_FWPPF = 8'h08;
  localparam logic [7:0] ADDR_GEN = 8'h0c;
  localparam logic [7:0] ADDR_VITC = 8'h10;
  localparam logic [7:0] ADDR_TRIM = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [2:0] PRM_LAST = 3'h4;
  localparam logic [2:0] IDX_TRIM = 3'h5;
  localparam logic [2:0] IDX_STAT = 3'h6;
  // ****************************************************************
  // Defaults
  // ****************************************************************
  localparam logic [31:0] CTRL_DEF = 32'h0000_0000;
  localparam logic [31:0] CFG_DEF = 32'h0000_0150;
  localparam logic [31:0] FWPPF_DEF = 32'h0064_0008;
  localparam logic [31:0] GEN_DEF = 32'h0000_0000;
  localparam logic [31:0] VITC_DEF = 32'h00ff_100e;
  localparam logic [4:0][31:0] PRM_DEF = {VITC_DEF, GEN_DEF, FWPPF_DEF, CFG_DEF, CTRL_DEF};
  localparam logic signed [11:0] TRIM_MAX = 12'sh3e7;
  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [2:0] CR_VIDEO_IN = 3'h1;
  localparam logic [2:0] CR_VIDEO_REF = 3'h2;
  localparam logic [1:0] POS_GENERATE = 2'h0;
  localparam logic [3:0] ITEM_LAST = 4'h9;
  localparam logic [3:0] VIDEO_SYSTEM_MENU_ITEM = 4'h8;
  localparam logic [3:0] OSCILLATOR_TRIM_MENU_ITEM = 4'hf;
  typedef enum logic [2:0] {
    MS_LOAD = 3'b000, MS_STORE = 3'b001, MS_BANNER = 3'b010, MS_TC = 3'b011,
    MS_ITEM = 3'b100, MS_UNLOCK = 3'b101, MS_TRIM_ITEM = 3'b110, MS_TRIM_EDIT = 3'b111
  } stv_menu_t;
  typedef enum logic [1:0] {
    DISP_TC = 2'b00, DISP_ITEM = 2'b01, DISP_VALUE = 2'b10, DISP_BANNER = 2'b11
  } stv_disp_t;
endpackage

// file: common/stv_sw_if.sv
interface stv_sw_if;
  logic set_p;
  logic up_p;
  logic up_r;
  logic down_p;
  logic clk_p;
  logic up_h;
  logic down_h;
  logic clk_h;
  modport src (output set_p, up_p, up_r, down_p, clk_p, up_h, down_h, clk_h);
  modport snk (input set_p, up_p, up_r, down_p, clk_p, up_h, down_h, clk_h);
endinterface

// file: logic/stv_switch.sv
module stv_switch (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] sw_raw,
  stv_sw_if.src sw
);
  // Bit order: 0 Set, 1 Up, 2 Down, 3 Clock Ref
  typedef struct packed {
    logic [3:0] held;
    logic [3:0] press;
    logic [3:0] rel;
  } stv_sw_st_t;
  stv_sw_st_t st;
  stv_sw_st_t next_st;
  always_comb begin
    next_st.held = sw_raw;
    next_st.press = sw_raw & ~st.held;
    next_st.rel = ~sw_raw & st.held;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign sw.set_p = st.press[0];
  assign sw.up_p = st.press[1];
  assign sw.up_r = st.rel[1];
  assign sw.down_p = st.press[2];
  assign sw.clk_p = st.press[3];
  assign sw.up_h = st.held[1];
  assign sw.down_h = st.held[2];
  assign sw.clk_h = st.held[3];
endmodule

// file: logic/stv_route.sv
module stv_route (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] clk_ref,
  input wire logic [1:0] pos_ref,
  input wire logic vid_in_sync,
  input wire logic vid_ref_sync,
  output logic route_ref,
  output logic frame_edge
);
  typedef struct packed {
    logic route_ref;
    logic sync_q;
    logic frame_edge;
  } stv_rt_st_t;
  stv_rt_st_t st;
  stv_rt_st_t next_st;
  logic sel_sync;
  always_comb begin
    sel_sync = st.route_ref ? vid_ref_sync : vid_in_sync;
    next_st.route_ref = (clk_ref == stv_pkg::CR_VIDEO_IN || clk_ref == stv_pkg::CR_VIDEO_REF)
                        && pos_ref == stv_pkg::POS_GENERATE; // [R11] [R12]
    next_st.sync_q = sel_sync;
    next_st.frame_edge = sel_sync & ~st.sync_q; // [R13]
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign route_ref = st.route_ref;
  assign frame_edge = st.frame_edge;
  property p_route_ref; // [R11]
    @(posedge core_clk) disable iff (sys_rst)
    ((clk_ref == stv_pkg::CR_VIDEO_IN || clk_ref == stv_pkg::CR_VIDEO_REF)
     && pos_ref == stv_pkg::POS_GENERATE) |=> route_ref;
  endproperty
  a_route_ref: assert property (p_route_ref) else $error("reference input not routed");
  property p_route_in; // [R12]
    @(posedge core_clk) disable iff (sys_rst)
    (pos_ref != stv_pkg::POS_GENERATE
     || (clk_ref != stv_pkg::CR_VIDEO_IN && clk_ref != stv_pkg::CR_VIDEO_REF))
    |=> !route_ref;
  endproperty
  a_route_in: assert property (p_route_in) else $error("program input not routed");
  property p_edge; // [R13]
    @(posedge core_clk) disable iff (sys_rst)
    (!route_ref && !vid_in_sync) ##1 (!route_ref && vid_in_sync) |=> frame_edge;
  endproperty
  a_edge: assert property (p_edge) else $error("frame edge missed");
endmodule

// file: logic/stv_top.sv
module stv_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_set,
  input wire logic sw_up,
  input wire logic sw_down,
  input wire logic sw_clkref,
  input wire logic vid_in_sync,
  input wire logic vid_ref_sync,
  input wire logic [31:0] nv_rdata,
  output logic [2:0] nv_raddr,
  output logic nv_wr,
  output logic [2:0] nv_waddr,
  output logic [31:0] nv_wdata,
  output logic [1:0] disp_mode,
  output logic [3:0] disp_item,
  output logic [11:0] disp_value,
  output logic factory_restore_banner,
  output logic [11:0] osc_trim,
  output logic [2:0] resolver_sel,
  output logic route_ref,
  output logic frame_edge
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    stv_pkg::stv_menu_t ms;
    logic [2:0] idx;
    logic restore;
    logic armed;
    logic [3:0] item;
    logic signed [11:0] edit_val;
    logic signed [11:0] trim;
    logic [4:0][31:0] prm;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nv_wr;
    logic [2:0] nv_waddr;
    logic [2:0] nv_raddr;
    logic [31:0] nv_wdata;
    stv_pkg::stv_disp_t disp;
    logic [3:0] disp_item;
    logic signed [11:0] disp_value;
    logic banner;
  } stv_top_st_t;

  stv_top_st_t st;
  stv_top_st_t next_st;
  stv_sw_if sw ();
  logic [2:0] ap_idx;
  logic ap_ok;
  logic bus_open;
  logic [2:0] word;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Adds a step and clamps to the displayable trim range
  function automatic logic signed [11:0] trim_add(input logic signed [11:0] v,
                                                  input logic signed [1:0] d);
    logic signed [12:0] s;
    s = 13'(v) + 13'(d);
    if (s > 13'(stv_pkg::TRIM_MAX)) begin
      trim_add = stv_pkg::TRIM_MAX;
    end else if (s < -13'(stv_pkg::TRIM_MAX)) begin
      trim_add = -stv_pkg::TRIM_MAX;
    end else begin
      trim_add = s[11:0];
    end
  endfunction

  // Word-aligned decode of the seven register slots
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= stv_pkg::ADDR_STAT);
  endfunction

  function automatic logic [31:0] trim_word(input logic signed [11:0] t);
    trim_word = {{20{t[11]}}, t};
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  stv_switch u_switch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sw_raw({sw_clkref, sw_down, sw_up, sw_set}),
    .sw(sw.src)
  );

  stv_route u_route (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_ref(st.prm[0][2:0]),
    .pos_ref(st.prm[0][4:3]),
    .vid_in_sync(vid_in_sync),
    .vid_ref_sync(vid_ref_sync),
    .route_ref(route_ref),
    .frame_edge(frame_edge)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.nv_wr = 1'b0;
    ap_ok = addr_ok(paddr);
    ap_idx = paddr[4:2];
    word = st.idx - 3'h1;
    // Bus is held off while the store is walked and while trim is edited,
    // so an APB write never meets a menu write on the storage port
    bus_open = st.ms != stv_pkg::MS_LOAD && st.ms != stv_pkg::MS_STORE
               && st.ms != stv_pkg::MS_TRIM_EDIT;

    // APB: one wait state, write lands at the edge that sees pready
    if (psel && penable && st.pready) begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      if (pwrite && ap_ok && ap_idx <= stv_pkg::PRM_LAST) begin
        next_st.prm[ap_idx] = pwdata; // [R10]
        next_st.nv_wr = 1'b1; // [R14]
        next_st.nv_waddr = ap_idx;
        next_st.nv_wdata = pwdata;
      end
    end else if (psel && penable && bus_open) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !ap_ok;
      if (!ap_ok || pwrite) begin
        next_st.prdata = 32'h0000_0000;
      end else if (ap_idx <= stv_pkg::PRM_LAST) begin
        next_st.prdata = st.prm[ap_idx];
      end else if (ap_idx == stv_pkg::IDX_TRIM) begin
        next_st.prdata = trim_word(st.trim);
      end else begin
        next_st.prdata = {24'h00_0000, st.ms, st.restore, st.armed, 1'b0, route_ref, frame_edge};
      end
    end

    // Front-panel menu and storage walks
    unique case (st.ms)
      stv_pkg::MS_LOAD: begin
        if (st.idx == 3'h0) begin
          next_st.restore = sw_up && sw_down; // [R7]
        end else if (word == stv_pkg::IDX_TRIM) begin
          next_st.trim = trim_add(nv_rdata[11:0], 2'sb00); // [R6] [R15]
        end else if (!st.restore) begin
          next_st.prm[word] = nv_rdata; // [R14]
        end
        next_st.nv_raddr = st.idx + 3'h1;
        next_st.idx = st.idx + 3'h1;
        if (st.idx == stv_pkg::IDX_STAT) begin
          next_st.idx = 3'h0;
          next_st.nv_raddr = 3'h0;
          next_st.ms = st.restore ? stv_pkg::MS_STORE : stv_pkg::MS_TC;
        end
      end
      stv_pkg::MS_STORE: begin
        // Defaults stay in prm from reset; write them back, trim word untouched
        next_st.nv_wr = 1'b1; // [R8] [R9] [R6]
        next_st.nv_waddr = st.idx;
        next_st.nv_wdata = st.prm[st.idx];
        next_st.idx = st.idx + 3'h1;
        if (st.idx == stv_pkg::PRM_LAST) begin
          next_st.idx = 3'h0;
          next_st.ms = stv_pkg::MS_BANNER;
        end
      end
      stv_pkg::MS_BANNER: begin
        if (!sw.up_h && !sw.down_h) begin
          next_st.ms = stv_pkg::MS_TC;
        end
      end
      stv_pkg::MS_TC: begin
        if (sw.set_p) begin
          next_st.item = 4'h0;
          next_st.ms = st.armed ? stv_pkg::MS_TRIM_ITEM : stv_pkg::MS_ITEM; // [R5]
        end
      end
      stv_pkg::MS_ITEM: begin
        // Up steps on release so a held Up can start the unlock gesture
        if (sw.set_p) begin
          next_st.ms = stv_pkg::MS_TC;
        end else if (st.item == stv_pkg::VIDEO_SYSTEM_MENU_ITEM && sw.up_h && sw.clk_p) begin
          next_st.ms = stv_pkg::MS_UNLOCK; // [R3]
        end else if (sw.up_r) begin
          next_st.item = (st.item == stv_pkg::ITEM_LAST) ? 4'h0 : st.item + 4'h1;
        end else if (sw.down_p) begin
          next_st.item = (st.item == 4'h0) ? stv_pkg::ITEM_LAST : st.item - 4'h1;
        end
      end
      stv_pkg::MS_UNLOCK: begin
        if (!sw.up_h && !sw.clk_h) begin
          next_st.armed = 1'b1; // [R3]
          next_st.ms = stv_pkg::MS_TRIM_ITEM;
        end
      end
      stv_pkg::MS_TRIM_ITEM: begin
        if (sw.set_p) begin
          next_st.edit_val = st.trim;
          next_st.ms = stv_pkg::MS_TRIM_EDIT;
        end else if (sw.down_p) begin
          next_st.armed = 1'b0; // [R5]
          next_st.ms = stv_pkg::MS_TC;
        end
      end
      stv_pkg::MS_TRIM_EDIT: begin
        if (sw.set_p) begin
          next_st.trim = st.edit_val; // [R4] [R15]
          next_st.nv_wr = 1'b1; // [R14]
          next_st.nv_waddr = stv_pkg::IDX_TRIM;
          next_st.nv_wdata = trim_word(st.edit_val);
          next_st.ms = stv_pkg::MS_TC;
        end else if (sw.up_p) begin
          next_st.edit_val = trim_add(st.edit_val, 2'sb01); // [R2]
        end else if (sw.down_p) begin
          next_st.edit_val = trim_add(st.edit_val, -2'sb01); // [R2]
        end
      end
    endcase

    // Display follows the state being entered
    next_st.disp_item = next_st.item;
    next_st.disp_value = next_st.edit_val;
    next_st.banner = 1'b0;
    unique case (next_st.ms)
      stv_pkg::MS_LOAD, stv_pkg::MS_STORE, stv_pkg::MS_TC: begin
        next_st.disp = stv_pkg::DISP_TC;
      end
      stv_pkg::MS_BANNER: begin
        next_st.disp = stv_pkg::DISP_BANNER;
        next_st.banner = 1'b1; // [R7]
      end
      stv_pkg::MS_ITEM, stv_pkg::MS_UNLOCK: begin
        next_st.disp = stv_pkg::DISP_ITEM;
      end
      stv_pkg::MS_TRIM_ITEM: begin
        next_st.disp = stv_pkg::DISP_ITEM;
        next_st.disp_item = stv_pkg::OSCILLATOR_TRIM_MENU_ITEM;
      end
      stv_pkg::MS_TRIM_EDIT: begin
        next_st.disp = stv_pkg::DISP_VALUE; // [R2]
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.prm <= stv_pkg::PRM_DEF;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign nv_raddr = st.nv_raddr;
  assign nv_wr = st.nv_wr;
  assign nv_waddr = st.nv_waddr;
  assign nv_wdata = st.nv_wdata;
  assign disp_mode = st.disp;
  assign disp_item = st.disp_item;
  assign disp_value = st.disp_value;
  assign factory_restore_banner = st.banner;
  // Signed count of 1/64 sample-period steps for the oscillator control
  assign osc_trim = st.trim; // [R1] [R15]
  assign resolver_sel = st.prm[0][2:0]; // [R10]

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_trim_range; // [R2]
    @(posedge core_clk) disable iff (sys_rst)
    st.trim <= stv_pkg::TRIM_MAX && st.trim >= -stv_pkg::TRIM_MAX
    && st.edit_val <= stv_pkg::TRIM_MAX && st.edit_val >= -stv_pkg::TRIM_MAX;
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("trim outside range");

  property p_unlock; // [R3]
    @(posedge core_clk) disable iff (sys_rst)
    $rose(st.armed) |-> $past(st.ms) == stv_pkg::MS_UNLOCK && disp_item
                        == stv_pkg::OSCILLATOR_TRIM_MENU_ITEM;
  endproperty
  a_unlock: assert property (p_unlock) else $error("trim item shown without unlock");

  property p_commit; // [R4]
    @(posedge core_clk) disable iff (sys_rst)
    (st.ms == stv_pkg::MS_TRIM_EDIT && sw.set_p) |=>
      osc_trim == $past(st.edit_val) && disp_mode == stv_pkg::DISP_TC
      && nv_wr && nv_waddr == stv_pkg::IDX_TRIM;
  endproperty
  a_commit: assert property (p_commit) else $error("trim commit wrong");

  property p_hide; // [R5]
    @(posedge core_clk) disable iff (sys_rst)
    (st.ms == stv_pkg::MS_TRIM_ITEM && sw.down_p && !sw.set_p) |=>
      !st.armed && st.ms == stv_pkg::MS_TC && disp_mode == stv_pkg::DISP_TC;
  endproperty
  a_hide: assert property (p_hide) else $error("trim item not hidden");

  property p_restore_trim; // [R6]
    @(posedge core_clk) disable iff (sys_rst)
    st.ms == stv_pkg::MS_STORE |=> $stable(osc_trim) && !(nv_wr && nv_waddr == stv_pkg::IDX_TRIM);
  endproperty
  a_restore_trim: assert property (p_restore_trim) else $error("restore touched trim");

  property p_banner; // [R7]
    @(posedge core_clk) disable iff (sys_rst)
    $rose(factory_restore_banner) |-> st.restore ##1 (factory_restore_banner || !sw.up_h);
  endproperty
  a_banner: assert property (p_banner) else $error("banner without restore");

  property p_defaults; // [R8]
    @(posedge core_clk) disable iff (sys_rst)
    $rose(factory_restore_banner) |-> st.prm[1] == stv_pkg::CFG_DEF
                                      && st.prm[2] == stv_pkg::FWPPF_DEF;
  endproperty
  a_defaults: assert property (p_defaults) else $error("restore defaults wrong");

  property p_defaults2; // [R9]
    @(posedge core_clk) disable iff (sys_rst)
    $rose(factory_restore_banner) |-> st.prm[3] == stv_pkg::GEN_DEF
                                      && st.prm[4] == stv_pkg::VITC_DEF;
  endproperty
  a_defaults2: assert property (p_defaults2) else $error("restore defaults wrong");

  property p_apb_write; // [R14]
    @(posedge core_clk) disable iff (sys_rst)
    (psel && penable && pready && pwrite && paddr == stv_pkg::ADDR_CTRL) |=>
      nv_wr && nv_waddr == 3'h0 && resolver_sel == $past(pwdata[2:0]);
  endproperty
  a_apb_write: assert property (p_apb_write) else $error("control write lost");
endmodule

// file: sim/stv_nv_model.sv
module stv_nv_model #(
  parameter logic [31:0] TRIM_INIT = 32'h0000_007b
) (
  input wire logic core_clk,
  input wire logic [2:0] nv_raddr,
  output logic [31:0] nv_rdata,
  input wire logic nv_wr,
  input wire logic [2:0] nv_waddr,
  input wire logic [31:0] nv_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Store contents, kept between resets
  // ********
  logic [31:0] mem [8] = '{5: TRIM_INIT, default: 32'h0000_0000};
  // Read data follows the address one cycle later
  always @(posedge core_clk) begin
    nv_rdata <= mem[nv_raddr];
    if (nv_wr === 1'h1) begin
      mem[nv_waddr] <= nv_wdata;
    end
  end
endmodule

// file: sim/test_settings_trim_video_route.sv
module test_settings_trim_video_route;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Signals
  // ********
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] sw = 4'h0;
  logic vid_in_sync = 1'h0;
  logic vid_ref_sync = 1'h0;
  logic [31:0] nv_rdata;
  logic [2:0] nv_raddr;
  logic nv_wr;
  logic [2:0] nv_waddr;
  logic [31:0] nv_wdata;
  logic [1:0] disp_mode;
  logic [3:0] disp_item;
  logic [11:0] disp_value;
  logic factory_restore_banner;
  logic [11:0] osc_trim;
  logic [2:0] resolver_sel;
  logic route_ref;
  logic frame_edge;
  int fe_cnt = 0;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int num_checks = 0;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (frame_edge === 1'h1) fe_cnt <= fe_cnt + 1;

  stv_top stv_top_i (.core_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .sw_set(sw[0]), .sw_up(sw[1]), .sw_down(sw[2]),
    .sw_clkref(sw[3]), .vid_in_sync, .vid_ref_sync, .nv_rdata, .nv_raddr, .nv_wr,
    .nv_waddr, .nv_wdata, .disp_mode, .disp_item, .disp_value, .factory_restore_banner,
    .osc_trim, .resolver_sel, .route_ref, .frame_edge);
  stv_nv_model stv_nv_model_i (.core_clk, .nv_raddr, .nv_rdata, .nv_wr, .nv_waddr,
    .nv_wdata);

  // ********
  // Shared tasks
  // ********
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1 && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 300) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // One switch held for three cycles, then idle for four
  task press(input int b);
    @(posedge core_clk);
    sw[b] <= 1'h1;
    cyc(3);
    sw[b] <= 1'h0;
    cyc(4);
    @(negedge core_clk);
  endtask

  task sync_pulse(input logic use_ref, input logic exp);
    int c0;
    @(negedge core_clk);
    c0 = fe_cnt;
    @(posedge core_clk);
    if (use_ref) vid_ref_sync <= 1'h1;
    else vid_in_sync <= 1'h1;
    cyc(3);
    vid_ref_sync <= 1'h0;
    vid_in_sync <= 1'h0;
    cyc(3);
    @(negedge core_clk);
    chk("frame_edge", 32'(fe_cnt - c0), 32'(exp));
  endtask

  // ********
  // Scenarios
  // ********
  task t_load;
    apb(1'h0, 8'h14, 32'h0);
    chk("trim_reg", rd, 32'h0000_007b);
    chk("trim_err", 32'(err), 32'h0);
    chk("osc_trim", 32'(osc_trim), 32'h0000_007b);
    apb(1'h1, 8'h14, 32'h0000_0100);
    chk("ro_write_err", 32'(err), 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk("trim_ro", rd, 32'h0000_007b);
    apb(1'h0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'(err), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk("status", rd, 32'h0000_0060);
    $display("t_load done");
  endtask

  task t_route;
    logic [31:0] v [6];
    logic [5:0] e;
    v = '{32'h01, 32'h02, 32'h00, 32'h09, 32'h12, 32'h04};
    e = 6'h03;
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, 8'h00, v[i]);
      cyc(3);
      @(negedge core_clk);
      chk("resolver_sel", 32'(resolver_sel), v[i] & 32'h7);
      chk("route_ref", 32'(route_ref), 32'(e[i]));
      chk("store_ctrl", stv_nv_model_i.mem[0], v[i]);
      sync_pulse(1'h1, e[i]);
      sync_pulse(1'h0, !e[i]);
    end
    $display("t_route done");
  endtask

  task t_trim;
    press(0);
    chk("first_item", 32'(disp_item), 32'h0);
    chk("item_mode", 32'(disp_mode), 32'h1);
    press(2);
    chk("wrap_down", 32'(disp_item), 32'h9);
    press(1);
    chk("wrap_up", 32'(disp_item), 32'h0);
    repeat (8) press(1);
    chk("video_item", 32'(disp_item), 32'h8);
    @(posedge core_clk);
    sw[1] <= 1'h1;
    cyc(3);
    sw[3] <= 1'h1;
    cyc(3);
    sw[3] <= 1'h0;
    cyc(3);
    sw[1] <= 1'h0;
    cyc(4);
    @(negedge core_clk);
    chk("trim_item", 32'(disp_item), 32'hf);
    press(0);
    chk("edit_mode", 32'(disp_mode), 32'h2);
    chk("edit_start", 32'(disp_value), 32'h07b);
    repeat (1200) press(2);
    chk("clamp_low", 32'(disp_value), 32'hc19);
    press(1);
    chk("step_up", 32'(disp_value), 32'hc1a);
    press(0);
    chk("commit", 32'(osc_trim), 32'hc1a);
    chk("back_tc", 32'(disp_mode), 32'h0);
    chk("store_trim", 32'(stv_nv_model_i.mem[5][11:0]), 32'hc1a);
    press(0);
    chk("trim_again", 32'(disp_item), 32'hf);
    press(2);
    chk("hide_tc", 32'(disp_mode), 32'h0);
    press(0);
    chk("hidden", 32'(disp_item), 32'h0);
    press(0);
    chk("item_exit", 32'(disp_mode), 32'h0);
    $display("t_trim done");
  endtask

  task t_restore;
    logic [31:0] d [5];
    d = '{32'h0, 32'h0000_0150, 32'h0064_0008, 32'h0, 32'h00ff_100e};
    @(posedge core_clk);
    sw <= 4'h6;
    sys_rst <= 1'h1;
    cyc(4);
    sys_rst <= 1'h0;
    // Both switches stay held until the banner shows
    cyc(30);
    @(negedge core_clk);
    chk("banner", 32'(factory_restore_banner), 32'h1);
    chk("banner_mode", 32'(disp_mode), 32'h3);
    @(posedge core_clk);
    sw <= 4'h0;
    cyc(8);
    @(negedge core_clk);
    chk("banner_off", 32'(factory_restore_banner), 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 8'(4 * i), 32'h0);
      chk("default_reg", rd, d[i]);
      chk("default_store", stv_nv_model_i.mem[i], d[i]);
    end
    chk("trim_kept", 32'(stv_nv_model_i.mem[5][11:0]), 32'hc1a);
    chk("osc_kept", 32'(osc_trim), 32'hc1a);
    apb(1'h0, 8'h14, 32'h0);
    chk("trim_sext", rd, 32'hffff_fc1a);
    $display("t_restore done");
  endtask

  // ********
  // Run
  // ********
  initial begin
    cyc(4);
    sys_rst <= 1'h0;
    t_load;
    t_route;
    t_trim;
    t_restore;
    final_report;
  end

  initial begin
    #3000000;
    error_cnt++;
    final_report;
  end
endmodule
